// File: fcc_top.sv
// Functional notes
// - Fence bit tells whether the display buffer lies in a CPU fence.
// - Bit 27 set stops command-stream sync flips resetting the compressor.
// - Bit 26 set stops register-write sync flips resetting the compressor.
// - Limit field sets minimum compression ratio and compressed buffer size.
// - Limit 00b 1:1, 01b 2:1, 10b 4:1, 11b reserved.
//
// Top of the frame compression control block: APB slave with a control
// and a status register, enable timing and compressor reset requests.
// Assumes vblank_start, cs_flip and reg_flip are one-cycle pulses on pclk.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module fcc_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Display events
  input  wire logic        vblank_start,
  input  wire logic        cs_flip,
  input  wire logic        reg_flip,
  // Compressor control
  output var  logic        comp_active,
  output var  logic        comp_reset,
  output var  logic        plane_sel,
  output var  logic        cpu_fence,
  output var  logic        keep_state_mode,
  output var  logic [1:0]  buf_shift,
  output var  logic        limit_bad
);
  import fcc_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic        act_r;
  logic        act_nxt;
  logic        crst_r;
  logic        crst_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic        rdy_r;
  logic        rdy_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [1:0]  shf_r;
  logic        bad_r;

  fcc_lim_if lim ();

  fcc_limit_dec u_dec (
    .lim (lim)
  );

  assign lim.limit = ctrl_r[FCC_LIM_LO +: 2];

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Answer every access in the cycle after its first access cycle: one wait state.
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  assign acc      = psel && penable && !rdy_r;
  assign hit_ctrl = paddr == FCC_CTRL_OFS;
  assign hit_stat = paddr == FCC_STAT_OFS;

  always_comb begin
    logic [31:0] wv;
    wv       = apply_strb(ctrl_r, pwdata, pstrb) & FCC_CTRL_MASK;
    ctrl_nxt = ctrl_r;
    rd_nxt   = 32'h00000000;
    rdy_nxt  = acc;
    err_nxt  = 1'b0;
    if (acc) begin
      if (hit_ctrl && pwrite) begin
        // While active only the enable may change; a locked write
        // keeps the other fields so a careless driver cannot corrupt them.
        if (act_r) begin
          ctrl_nxt[FCC_EN_BIT] = wv[FCC_EN_BIT];
        end else begin
          ctrl_nxt = wv;
        end
      end else if (hit_ctrl) begin
        rd_nxt = ctrl_r;
      end else if (hit_stat && !pwrite) begin
        rd_nxt = {28'h0000000, bad_r, shf_r, act_r};
      end else if (!hit_stat) begin
        err_nxt = 1'b1;
      end
    end
  end

  always_comb begin
    act_nxt = act_r;
    if (vblank_start) begin
      act_nxt = ctrl_r[FCC_EN_BIT];
    end
    crst_nxt = (cs_flip && !ctrl_r[FCC_CS_BLK_BIT]) ||
               (reg_flip && !ctrl_r[FCC_REG_BLK_BIT]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= FCC_CTRL_RST;
      act_r  <= 1'b0;
      crst_r <= 1'b0;
      rd_r   <= 32'h00000000;
      rdy_r  <= 1'b0;
      err_r  <= 1'b0;
      shf_r  <= 2'h0;
      bad_r  <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      act_r  <= act_nxt;
      crst_r <= crst_nxt;
      rd_r   <= rd_nxt;
      rdy_r  <= rdy_nxt;
      err_r  <= err_nxt;
      shf_r  <= lim.shift;
      bad_r  <= lim.bad;
    end
  end

  always_comb begin
    prdata          = rd_r;
    pready          = rdy_r;
    pslverr         = err_r;
    comp_active     = act_r;
    comp_reset      = crst_r;
    plane_sel       = ctrl_r[FCC_PLANE_BIT];
    cpu_fence       = ctrl_r[FCC_FENCE_BIT];
    keep_state_mode = ctrl_r[FCC_KEEP_BIT];
    buf_shift       = shf_r;
    limit_bad       = bad_r;
  end
endmodule
`default_nettype wire

// File: fcc_pkg.sv
// Package for the frame compression control block: register map,
// field positions, reset values and the limit encoding.
// Assumes a 32-bit APB register bus with word-aligned registers.
package fcc_pkg;

  // Register byte offsets.
  localparam logic [11:0] FCC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FCC_STAT_OFS   = 12'h004;

  // Control field positions.
  localparam int FCC_EN_BIT       = 31;
  localparam int FCC_PLANE_BIT    = 30;
  localparam int FCC_FENCE_BIT    = 29;
  localparam int FCC_CS_BLK_BIT   = 27;
  localparam int FCC_REG_BLK_BIT  = 26;
  localparam int FCC_KEEP_BIT     = 25;
  localparam int FCC_LIM_LO       = 6;

  // Bits of the control register that are writable.
  localparam logic [31:0] FCC_CTRL_MASK  = 32'hEE0000C0;
  localparam logic [31:0] FCC_CTRL_RST   = 32'h00000000;

  // Compression limit encoding.
  localparam logic [1:0] FCC_LIM_1TO1  = 2'h0;
  localparam logic [1:0] FCC_LIM_2TO1  = 2'h1;
  localparam logic [1:0] FCC_LIM_4TO1  = 2'h2;
  localparam logic [1:0] FCC_LIM_RSVD  = 2'h3;

  typedef enum logic [1:0] {
    FCC_RATIO_1,
    FCC_RATIO_2,
    FCC_RATIO_4,
    FCC_RATIO_BAD
  } fcc_ratio_type;

endpackage

// File: fcc_if.sv
// Interface carrying the compression limit decode between modules.
// Assumes both ends share pclk.
`timescale 1ns/1ns
`default_nettype none
interface fcc_lim_if;
  logic [1:0] limit;
  logic [1:0] shift;
  logic       bad;
  modport dec (input limit, output shift, output bad);
  modport use_side (output limit, input shift, input bad);
endinterface
`default_nettype wire

// File: fcc_limit_dec.sv
// Decoder from the compression limit field to a buffer size shift.
// Assumes the field is already registered by the caller.
`timescale 1ns/1ns
`default_nettype none
module fcc_limit_dec (
  fcc_lim_if.dec lim
);
  import fcc_pkg::*;

  always_comb begin
    lim.bad = 1'b0;
    case (lim.limit)
      FCC_LIM_1TO1: lim.shift = 2'h0;
      FCC_LIM_2TO1: lim.shift = 2'h1;
      FCC_LIM_4TO1: lim.shift = 2'h2;
      default: begin
        lim.shift = 2'h0;
        lim.bad   = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: fcc_props.sv
// Checker for the frame compression control block ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module fcc_props (
  // Bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Display side
  input wire logic        vblank_start,
  input wire logic        cs_flip,
  input wire logic        reg_flip,
  input wire logic        comp_active,
  input wire logic        comp_reset,
  input wire logic        cpu_fence,
  input wire logic [1:0]  buf_shift,
  input wire logic        limit_bad
);
  // Shadow of fence, both blocks and limit; frozen while compression runs.
  // It is taken at the same access edge at which the block takes a write.
  logic [4:0] c_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) c_r <= 5'h00;
    else if (psel && penable && !pready && pwrite && paddr == 12'h000 &&
             !comp_active)
      c_r <= {pwdata[29], pwdata[27:26], pwdata[7:6]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_en; $changed(comp_active) |-> $past(vblank_start); endproperty
  a_en: assert property (p_en) else $error("active moved");
  property p_cs; cs_flip && !reg_flip |=> comp_reset != $past(c_r[3]);
  endproperty
  a_cs: assert property (p_cs) else $error("cs flip reset");
  property p_rg; reg_flip && !cs_flip |=> comp_reset != $past(c_r[2]);
  endproperty
  a_rg: assert property (p_rg) else $error("reg flip reset");
  property p_fn; $stable(c_r) |-> cpu_fence == c_r[4]; endproperty
  a_fn: assert property (p_fn) else $error("fence level");
  property p_sh; $stable(c_r) && c_r[1:0] != 2'h3 |=>
    buf_shift == $past(c_r[1:0]);
  endproperty
  a_sh: assert property (p_sh) else $error("buffer shift");
  property p_bd; $stable(c_r) |=> limit_bad == ($past(c_r[1:0]) == 2'h3);
  endproperty
  a_bd: assert property (p_bd) else $error("reserved limit");
  property p_rs; disable iff (1'b0) $rose(presetn) |-> !comp_active &&
    !comp_reset && !cpu_fence && buf_shift == 2'h0; endproperty
  a_rs: assert property (p_rs) else $error("reset state");
endmodule
bind fcc_top fcc_props u_fcc_props (.*);
`default_nettype wire

// File: fcc_tb_top.sv
// Self-checking bench for the frame compression control block.
// Assumes a 25 MHz pclk; the bench is the APB master and event source.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module fcc_tb_top;
  import fcc_pkg::*;
  logic pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [2:0] ev = 3'h0;
  logic pready, pslverr, comp_active, comp_reset, cpu_fence, limit_bad;
  logic [1:0] buf_shift;
  int fails = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  fcc_top u_fcc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .vblank_start(ev[2]), .cs_flip(ev[1]), .reg_flip(ev[0]), .comp_active,
    .comp_reset, .plane_sel(), .cpu_fence, .keep_state_mode(), .buf_shift,
    .limit_bad);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge pclk) ev <= m;
    @(posedge pclk) ev <= 3'h0;
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    give_verdict;
  end
  initial begin
    // Reset goes low by an event so the block's asynchronous reset fires.
    presetn <= 1'b0;
    void'($urandom(71));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 24; i++) begin
      v = $urandom & 32'h7FFFFFFF;
      if (i < 4) v[7:6] = i[1:0];
      apb(1, 12'h000, v);
      apb(0, 12'h000, 0);
      `CHK(rd, v & FCC_CTRL_MASK)
      `CHK(cpu_fence, v[29])
      `CHK(limit_bad, v[7:6] == 2'h3)
      if (v[7:6] != 2'h3) `CHK(buf_shift, v[7:6])
      pulse(3'h2);
      `CHK(comp_reset, !v[27])
      pulse(3'h1);
      `CHK(comp_reset, !v[26])
    end
    $display("field test done");
    v = 32'h8C000040;
    apb(1, 12'h000, v);
    `CHK(comp_active, 1'b0)
    pulse(3'h4);
    `CHK(comp_active, 1'b1)
    apb(1, 12'h000, 32'hA0000080);
    apb(0, 12'h000, 0);
    `CHK(rd, v)
    apb(1, 12'h000, 0);
    `CHK(comp_active, 1'b1)
    pulse(3'h4);
    `CHK(comp_active, 1'b0)
    apb(0, 12'h010, 0);
    `CHK(er, 1'b1)
    $display("enable test done");
    give_verdict;
  end
endmodule
`default_nettype wire
